// >>> design/psr_runner.sv
/*
 * protocol sequence runner: runs up to eight stored protocols in a
 * row on one of two serial channels and reports through a control
 * block per channel, end-of-scan flags and an interrupt.
 * assumes an external protocol engine per channel, a one-cycle
 * scan_end pulse and a register port with read data one cycle late.
 */
// How it works
// RULE1 - channel selector 1 or 2 only
// RULE2 - run count lies between one and eight
// RULE3 - result word zero, else last error
// RULE4 - execution count includes failed protocols
// RULE5 - invalid setup stores zero count, runs nothing
// RULE6 - requester fills protocol numbers, valid ranges
// RULE7 - receiving slot stores matched packet number
// RULE8 - failed, functional, or unrun slots store zero
// RULE9 - error stops sequence, later slots skipped
// RULE10 - second run on busy channel ignored
// RULE11 - reinit overlap fails the later command
// RULE12 - other protocol-mode command use fails run
// RULE13 - done flag lasts one scan
// RULE14 - error flag only on failure, one scan
// RULE15 - stored protocols run per block, chosen channel
// RULE16 - cancel word aborts run, answers two
// RULE17 - words written before done flag rises
`timescale 1ns/10ps
`default_nettype none
`include "psr_cfg.svh"

module psr_runner
   import psr_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic scan_end,
   input wire logic [1:0] reinit_busy,
   input wire logic [1:0] reinit_req,
   output logic [1:0] reinit_reject,
   input wire logic [1:0] mode_conflict,
   output logic [1:0] proto_start,
   output logic [1:0][7:0] proto_num,
   output logic [1:0] proto_abort,
   input wire logic [1:0] proto_done,
   input wire logic [1:0][15:0] proto_err,
   input wire logic [1:0] proto_rx,
   input wire logic [1:0][4:0] proto_pkt,
   output logic [1:0] busy,
   output logic [1:0] done_flag,
   output logic [1:0] err_flag,
   output logic irq
);

   psr_state_rec_t q;
   psr_state_rec_t d;
   logic [1:0] params_ok;
   logic [`PSR_NIRQ-1:0] sts_set;
   logic cmd_go;
   logic [1:0] cmd_ch;
   logic [3:0] next_slot;

   // protocol number is a stored or a functional one
   function automatic logic valid_proto(input logic [15:0] num);
      valid_proto = (num >= {8'h00, `PSR_STORED_MIN} &&
                     num <= {8'h00, `PSR_STORED_MAX}) ||
                    (num >= {8'h00, `PSR_FUNC_MIN} &&
                     num <= {8'h00, `PSR_FUNC_MAX});
   endfunction

   // functional protocols never report a packet number
   function automatic logic is_func(input logic [7:0] num);
      is_func = num >= `PSR_FUNC_MIN && num <= `PSR_FUNC_MAX;
   endfunction

   // word index of a slot relative to a field start
   function automatic logic [4:0] slot_word(input logic [4:0] base,
                                            input logic [3:0] slot);
      slot_word = base + {1'b0, slot};
   endfunction

   // address hits control block ch at a valid word
   function automatic logic cb_hit(input logic [7:0] addr,
                                   input logic ch);
      cb_hit = addr[7:6] == 2'h0 && addr[5] == ch &&
               addr[4:0] < 5'(`PSR_NWORDS);
   endfunction

   // run count and every used protocol slot must be legal
   function automatic logic check_block(input logic [3:0] cnt,
                                        input psr_block_t blk);
      int i;
      check_block = cnt >= 4'h1 && cnt <= `PSR_MAX_RUN;   // see RULE2
      for (i = 0; i < 8; i++) begin
         if (4'(i) < cnt &&
             !valid_proto(blk[slot_word(`PSR_CB_PROTO0, 4'(i))])) begin
            check_block = 1'b0;   // see RULE6
         end
      end
   endfunction

   assign params_ok[0] = check_block(q.cnt[0], q.cb[0]);
   assign params_ok[1] = check_block(q.cnt[1], q.cb[1]);
   assign cmd_go = reg_wr && reg_addr == `PSR_ADDR_CMD;
   assign cmd_ch = reg_wdata[`PSR_CMD_CH_MSB:`PSR_CMD_CH_LSB];

   // sequencers, control blocks, interrupt bits and register port
   always_comb begin
      d = q;
      d.rdata = 16'h0000;
      d.fin = 2'h0;
      sts_set = '0;
      next_slot = 4'h0;
      // software writes
      if (reg_wr) begin
         for (int c = 0; c < 2; c++) begin
            if (cb_hit(reg_addr, c[0])) begin
               d.cb[c][reg_addr[4:0]] = reg_wdata;
            end
         end
         case (reg_addr)
            `PSR_ADDR_CANCEL0: d.cancel[0] = reg_wdata;
            `PSR_ADDR_CANCEL1: d.cancel[1] = reg_wdata;
            `PSR_ADDR_MASK: d.mask = reg_wdata[`PSR_NIRQ-1:0];
            `PSR_ADDR_STATUS:
               d.irq_st = q.irq_st & ~reg_wdata[`PSR_NIRQ-1:0];
            default: ;
         endcase
      end
      // channel numbers other than one and two are refused
      if (cmd_go && cmd_ch != 2'h1 && cmd_ch != 2'h2) begin
         sts_set[`PSR_IRQ_BADCMD] = 1'b1;   // see RULE1
      end
      for (int c = 0; c < 2; c++) begin
         // reinit issued during a run is the later one and fails
         if (reinit_req[c] && q.st[c] != ST_IDLE) begin
            sts_set[`PSR_IRQ_CLASH] = 1'b1;   // see RULE11
         end
         case (q.st[c])
            ST_IDLE: begin
               if (cmd_go && cmd_ch == 2'(c + 1)) begin // see RULE10
                  d.cnt[c] = reg_wdata[`PSR_CMD_CNT_MSB:`PSR_CMD_CNT_LSB];
                  d.st[c] = ST_CHECK;
               end
               // cancel with nothing running completes at once
               if (q.cancel[c] == `PSR_CAN_REQ) begin
                  d.cancel[c] = `PSR_CAN_DONE;   // see RULE16
               end
            end
            ST_CHECK: begin
               // unrun slots read zero
               for (int i = 0; i < 8; i++) begin // see RULE8
                  d.cb[c][slot_word(`PSR_CB_PKT0, 4'(i))] = 16'h0000;
               end
               d.slot[c] = 4'h0;
               d.cb[c][`PSR_CB_COUNT] = 16'h0000;
               d.cb[c][`PSR_CB_RESULT] = `PSR_OK;
               d.fail[c] = 1'b1;
               d.st[c] = ST_FINISH;
               if (reinit_busy[c]) begin
                  d.cb[c][`PSR_CB_RESULT] = `PSR_ERR_SIMUL;   // see RULE11
               end else if (mode_conflict[c]) begin
                  d.cb[c][`PSR_CB_RESULT] = `PSR_ERR_MODE;   // see RULE12
               end else if (!params_ok[c]) begin
                  d.cb[c][`PSR_CB_RESULT] = `PSR_ERR_PARAM;   // see RULE5
               end else begin
                  d.fail[c] = 1'b0;
                  d.proto_num[c] = q.cb[c][`PSR_CB_PROTO0][7:0];
                  d.st[c] = ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               d.st[c] = ST_WAIT;
            end
            ST_WAIT: begin
               if (proto_done[c]) begin
                  next_slot = q.slot[c] + 4'h1;
                  // failed protocols are counted too
                  d.cb[c][`PSR_CB_COUNT] = {12'h000, next_slot}; // see RULE4
                  if (q.cancel[c] == `PSR_CAN_REQ) begin
                     // forced end, later slots skipped
                     d.cb[c][`PSR_CB_RESULT] = `PSR_ERR_CANCEL; // see RULE16
                     d.cancel[c] = `PSR_CAN_DONE;
                     d.fail[c] = 1'b1;
                     d.st[c] = ST_FINISH;
                  end else if (proto_err[c] != `PSR_OK) begin
                     d.cb[c][`PSR_CB_RESULT] = proto_err[c];   // see RULE3
                     d.fail[c] = 1'b1;
                     d.st[c] = ST_FINISH;   // see RULE9
                  end else begin
                     d.cb[c][`PSR_CB_RESULT] = `PSR_OK;   // see RULE3
                     if (proto_rx[c] && !is_func(q.proto_num[c])) begin
                        d.cb[c][slot_word(`PSR_CB_PKT0, q.slot[c])] =
                           {11'h000, proto_pkt[c]};   // see RULE7
                     end
                     if (next_slot == q.cnt[c]) begin
                        d.st[c] = ST_FINISH;
                     end else begin
                        d.slot[c] = next_slot;
                        d.proto_num[c] =
                           q.cb[c][slot_word(`PSR_CB_PROTO0, next_slot)][7:0];
                        d.st[c] = ST_ISSUE;
                     end
                  end
               end
            end
            ST_FINISH: begin
               // words already stand when the finish is reported
               d.fin[c] = 1'b1;   // see RULE17
               d.st[c] = ST_IDLE;
            end
            default: begin
               d.st[c] = ST_IDLE;
            end
         endcase
         sts_set[`PSR_IRQ_DONE0 + c] = q.fin[c];
         sts_set[`PSR_IRQ_ERR0 + c] = q.fin[c] & q.fail[c];
      end
      // hardware events win over a clear in the same cycle
      d.irq_st = d.irq_st | sts_set;
      // register reads, answered in the next cycle
      if (reg_rd) begin
         for (int c = 0; c < 2; c++) begin
            if (cb_hit(reg_addr, c[0])) begin
               d.rdata = q.cb[c][reg_addr[4:0]];
            end
         end
         case (reg_addr)
            `PSR_ADDR_CANCEL0: d.rdata = q.cancel[0];
            `PSR_ADDR_CANCEL1: d.rdata = q.cancel[1];
            `PSR_ADDR_STATUS: d.rdata = {10'h000, q.irq_st};
            `PSR_ADDR_MASK: d.rdata = {10'h000, q.mask};
            `PSR_ADDR_STATE:
               d.rdata = {10'h000, err_flag, done_flag, busy};
            default: ;
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.st <= {ST_IDLE, ST_IDLE};
      end else begin
         q <= d;
      end
   end

   // engine handshake and status outputs
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         proto_start[c] = q.st[c] == ST_ISSUE;   // see RULE15
         proto_abort[c] = q.st[c] == ST_WAIT &&
                          q.cancel[c] == `PSR_CAN_REQ;   // see RULE16
         busy[c] = q.st[c] != ST_IDLE;
         reinit_reject[c] = reinit_req[c] && q.st[c] != ST_IDLE;
      end
   end

   assign proto_num = q.proto_num;
   assign reg_rdata = q.rdata;
   assign irq = |(q.irq_st & q.mask);

   // end-of-scan flags, one stage per channel
   psr_scan_flag u_flag0 (
      .core_clk(core_clk),
      .nrst(nrst),
      .scan_end(scan_end),
      .finish(q.fin[0]),
      .failed(q.fail[0]),
      .done_flag(done_flag[0]),
      .err_flag(err_flag[0])
   );

   psr_scan_flag u_flag1 (
      .core_clk(core_clk),
      .nrst(nrst),
      .scan_end(scan_end),
      .finish(q.fin[1]),
      .failed(q.fail[1]),
      .done_flag(done_flag[1]),
      .err_flag(err_flag[1])
   );

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_reinit_clash;
      q.st[0] == ST_CHECK && reinit_busy[0];
   endsequence

   sequence s_fail_close(logic [15:0] code);
      q.cb[0][`PSR_CB_RESULT] == code && q.st[0] == ST_FINISH
      ##1 q.fin[0] && q.st[0] == ST_IDLE;
   endsequence

   busy_ignore_a: assert property ( // see RULE10
      cmd_go && cmd_ch == 2'h1 && q.st[0] != ST_IDLE |=> $stable(q.cnt[0]))
      else $error("run command taken on a busy channel");

   reinit_clash_a: assert property ( // see RULE11
      s_reinit_clash |=> s_fail_close(`PSR_ERR_SIMUL))
      else $error("reinit overlap did not fail with 7ff0");

   mode_clash_a: assert property ( // see RULE12
      q.st[0] == ST_CHECK && !reinit_busy[0] && mode_conflict[0]
      |=> s_fail_close(`PSR_ERR_MODE))
      else $error("mode conflict did not fail with 7ff2");

   bad_setup_a: assert property ( // see RULE5
      q.st[0] == ST_CHECK && !reinit_busy[0] && !mode_conflict[0] &&
      !params_ok[0] |=> q.cb[0][`PSR_CB_COUNT] == 16'h0000 &&
      !proto_start[0] ##1 !proto_start[0])
      else $error("invalid setup started a protocol");

   stop_on_error_a: assert property ( // see RULE9
      q.st[1] == ST_WAIT && proto_done[1] && proto_err[1] != 16'h0000 &&
      q.cancel[1] != `PSR_CAN_REQ |=> q.st[1] == ST_FINISH && q.fail[1]
      ##1 q.st[1] == ST_IDLE && !proto_start[1])
      else $error("sequence went on after a protocol error");

   issue_number_a: assert property ( // see RULE15
      proto_start[0] |-> proto_num[0] ==
      q.cb[0][slot_word(`PSR_CB_PROTO0, q.slot[0])][7:0])
      else $error("engine given a number other than the slot");

   count_bound_a: assert property ( // see RULE4
      q.fin[0] |-> q.cb[0][`PSR_CB_COUNT] <= 16'h0008 &&
      q.cb[0][`PSR_CB_COUNT] <= {12'h000, q.cnt[0]})
      else $error("execution count beyond the run count");

   cancel_idle_a: assert property ( // see RULE16
      q.st[0] == ST_IDLE && q.cancel[0] == `PSR_CAN_REQ && !reg_wr
      |=> q.cancel[0] == `PSR_CAN_DONE)
      else $error("idle cancel not answered with two");

endmodule

`default_nettype wire

// >>> pkg/psr_cfg.svh
/*
 * offsets, field positions, cancel word values and result codes of the
 * protocol sequence runner.
 * assumes a 16-bit register port with an 8-bit word address.
 */
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH

// register port addresses
`define PSR_CB_BASE0 8'h00
`define PSR_CB_BASE1 8'h20
`define PSR_ADDR_CMD 8'h40
`define PSR_ADDR_CANCEL0 8'h41
`define PSR_ADDR_CANCEL1 8'h42
`define PSR_ADDR_STATUS 8'h44
`define PSR_ADDR_MASK 8'h45
`define PSR_ADDR_STATE 8'h46

// control block layout, word indices
`define PSR_NWORDS 18
`define PSR_CB_RESULT 5'h00
`define PSR_CB_COUNT 5'h01
`define PSR_CB_PROTO0 5'h02
`define PSR_CB_PKT0 5'h0a
`define PSR_MAX_RUN 4'h8

// command word fields
`define PSR_CMD_CH_MSB 1
`define PSR_CMD_CH_LSB 0
`define PSR_CMD_CNT_MSB 7
`define PSR_CMD_CNT_LSB 4

// protocol number ranges
`define PSR_STORED_MIN 8'h01
`define PSR_STORED_MAX 8'h80
`define PSR_FUNC_MIN 8'hc9
`define PSR_FUNC_MAX 8'hcf

// result codes
`define PSR_OK 16'h0000
`define PSR_ERR_SIMUL 16'h7ff0
`define PSR_ERR_MODE 16'h7ff2
`define PSR_ERR_PARAM 16'h7ff1
`define PSR_ERR_CANCEL 16'h7ff3

// cancel word values
`define PSR_CAN_NONE 16'h0000
`define PSR_CAN_REQ 16'h0001
`define PSR_CAN_DONE 16'h0002

// interrupt status bits
`define PSR_NIRQ 6
`define PSR_IRQ_DONE0 0
`define PSR_IRQ_ERR0 2
`define PSR_IRQ_BADCMD 4
`define PSR_IRQ_CLASH 5

`endif

// >>> pkg/psr_pkg.sv
/*
 * types of the protocol sequence runner: sequencer states and the
 * state records of both modules.
 * assumes psr_cfg.svh is on the include path.
 */
`include "psr_cfg.svh"

package psr_pkg;

   // per-channel sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_CHECK = 5'b00010,
      ST_ISSUE = 5'b00100,
      ST_WAIT = 5'b01000,
      ST_FINISH = 5'b10000
   } psr_state_t;

   typedef logic [`PSR_NWORDS-1:0][15:0] psr_block_t;

   // whole state of the runner
   typedef struct packed {
      psr_block_t [1:0] cb;
      logic [1:0][15:0] cancel;
      psr_state_t [1:0] st;
      logic [1:0][3:0] slot;
      logic [1:0][3:0] cnt;
      logic [1:0][7:0] proto_num;
      logic [1:0] fin;
      logic [1:0] fail;
      logic [15:0] rdata;
      logic [`PSR_NIRQ-1:0] irq_st;
      logic [`PSR_NIRQ-1:0] mask;
   } psr_state_rec_t;

   // whole state of the scan flag stage
   typedef struct packed {
      logic pend;
      logic pend_fail;
      logic done;
      logic err;
   } psr_flag_t;

endpackage

// >>> design/psr_scan_flag.sv
/*
 * end-of-scan flag stage for one channel: holds a finish until the
 * next end-of-scan step and shows done and error for one scan.
 * assumes scan_end is a one-cycle pulse per processor scan.
 */
`timescale 1ns/10ps
`default_nettype none

module psr_scan_flag
   import psr_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic scan_end,
   input wire logic finish,
   input wire logic failed,
   output logic done_flag,
   output logic err_flag
);

   psr_flag_t q;
   psr_flag_t d;

   // a finish waits for the end-of-scan step, then lasts one scan
   always_comb begin
      d = q;
      if (finish) begin
         d.pend = 1'b1;
         d.pend_fail = failed;
      end
      if (scan_end) begin
         d.done = q.pend | finish;   // see RULE13
         d.err = finish ? failed : (q.pend & q.pend_fail);   // see RULE14
         d.pend = 1'b0;
         d.pend_fail = 1'b0;
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done_flag = q.done;
   assign err_flag = q.err;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   flag_scan_edge_a: assert property ( // see RULE13
      $changed(done_flag) |-> $past(scan_end))
      else $error("done flag moved outside an end-of-scan step");

   error_needs_done_a: assert property ( // see RULE14
      err_flag |-> done_flag)
      else $error("error flag high without done flag");

endmodule

`default_nettype wire

// >>> test/psr_engine_model.sv
/*
 * behavioural protocol engine for one channel of the sequence runner.
 * assumes one answer per start and that abort is honoured at once.
 */
`timescale 1ns/10ps
`default_nettype none

module psr_engine_model #(
   parameter logic [7:0] ERR_NUM = 8'h64,
   parameter logic [15:0] ERR_CODE = 16'h7d05
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic start,
   input wire logic [7:0] num,
   input wire logic abort,
   output logic done,
   output logic [15:0] err,
   output logic rx,
   output logic [4:0] pkt
);
   logic run_q;
   logic [7:0] num_q;
   logic [7:0] wait_q;

   // answer lines toggle outside the done cycle so stale use shows up
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
         num_q <= 8'h00;
         wait_q <= 8'h00;
         done <= 1'b0;
         err <= 16'h5a5a;
         rx <= 1'b0;
         pkt <= 5'h00;
      end else begin
         done <= 1'b0;
         err <= ~err;
         rx <= ~rx;
         pkt <= ~pkt;
         if (start) begin
            run_q <= 1'b1;
            num_q <= num;
            wait_q <= slow ? 8'hc8 : 8'h03;
         end else if (run_q && (abort || wait_q == 8'h00)) begin
            run_q <= 1'b0;
            done <= 1'b1;
            err <= (num_q == ERR_NUM) ? ERR_CODE : 16'h0000;
            rx <= num_q[0]; // odd numbers claim a packet, odd functional ones too
            pkt <= {1'b0, num_q[3:0]} + 5'h01;
         end else if (run_q) begin
            wait_q <= wait_q - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
/*
 * self-checking bench of the protocol sequence runner.
 * assumes psr_cfg.svh on the include path and two engine models.
 */
`timescale 1ns/10ps
`default_nettype none
`include "psr_cfg.svh"

module tb_top;
   localparam logic [15:0] ERR_CODE = 16'h7d05;
   logic core_clk, nrst, reg_wr, reg_rd, scan_end, irq;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [3:0] scan_q;
   logic [1:0] reinit_busy, reinit_req, reinit_reject, mode_conflict;
   logic [1:0] proto_start, proto_abort, proto_done, proto_rx, slow;
   logic [1:0] busy, done_flag, err_flag;
   logic [1:0][7:0] proto_num;
   logic [1:0][15:0] proto_err;
   logic [1:0][4:0] proto_pkt;
   logic [15:0] exp_pk [8];
   logic [11:0] bad [6];
   int n_fail, n_tests, cycles;
   int n_start [2];

   psr_runner psr_runner_i (.core_clk(core_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_end(scan_end),
      .reinit_busy(reinit_busy), .reinit_req(reinit_req),
      .reinit_reject(reinit_reject), .mode_conflict(mode_conflict),
      .proto_start(proto_start), .proto_num(proto_num),
      .proto_abort(proto_abort), .proto_done(proto_done),
      .proto_err(proto_err), .proto_rx(proto_rx), .proto_pkt(proto_pkt),
      .busy(busy), .done_flag(done_flag), .err_flag(err_flag), .irq(irq));

   // one engine per channel
   for (genvar c = 0; c < 2; c++) begin : g_eng
      psr_engine_model #(.ERR_CODE(ERR_CODE)) psr_engine_model_i (
         .core_clk(core_clk), .nrst(nrst), .slow(slow[c]),
         .start(proto_start[c]), .num(proto_num[c]),
         .abort(proto_abort[c]), .done(proto_done[c]),
         .err(proto_err[c]), .rx(proto_rx[c]), .pkt(proto_pkt[c]));
   end

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // scan pulse every 16 cycles, start counting and hang limit
   always @(posedge core_clk) begin
      scan_q <= scan_q + 4'h1;
      scan_end <= (scan_q == 4'he);
      cycles++;
      for (int c = 0; c < 2; c++) if (proto_start[c] === 1'b1) n_start[c]++;
      if (cycles == 20000) begin
         n_fail++;
         $display("[ERR] %0t timeout", $time);
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // bus cycles start and end just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask

   function automatic logic [7:0] base(input int ch);
      return ch ? `PSR_CB_BASE1 : `PSR_CB_BASE0;
   endfunction

   task automatic load(input int ch, input logic [7:0] p [8]);
      for (int i = 0; i < 8; i++) wr(base(ch) + 8'(i + 2), {8'h00, p[i]});
   endtask

   task automatic cmd(input int ch, input logic [3:0] cnt);
      wr(`PSR_ADDR_CMD, {8'h00, cnt, 4'(ch + 1)});
   endtask

   // wait for done, then measure how long it stands
   task automatic wait_done(input int ch, input logic ef);
      int w;
      w = 0;
      while (done_flag[ch] !== 1'b1 && w < 1000) begin
         @(posedge core_clk);
         #1 w++;
      end
      chk(16'(done_flag[ch]), 16'h0001);
      chk(16'(err_flag[ch]), 16'(ef));
      w = 0;
      while (done_flag[ch] === 1'b1 && w < 40) begin
         @(posedge core_clk);
         #1 w++;
      end
      chk(16'(w), 16'h0010);
      @(posedge core_clk);
   endtask

   // control block read back after the done flag has dropped
   task automatic chk_blk(input int ch, input logic [15:0] res,
                          input logic [3:0] cnt);
      rd(base(ch), rv);
      chk(rv, res);
      rd(base(ch) + 8'h01, rv);
      chk(rv, {12'h000, cnt});
      for (int i = 0; i < 8; i++) begin
         rd(base(ch) + 8'(10 + i), rv);
         chk(rv, exp_pk[i]);
      end
   endtask

   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, scan_q, scan_end} = '0;
      {reinit_busy, reinit_req, mode_conflict, slow} = '0;
      {n_fail, n_tests, cycles} = '0;
      n_start = '{0, 0};
      bad = '{{4'h0, 8'h01}, {4'h9, 8'h01}, {4'h1, 8'h00},
              {4'h1, 8'h81}, {4'h1, 8'hc8}, {4'h1, 8'hd0}};
      nrst = 1'b0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(`PSR_ADDR_STATE, rv);
      chk(rv, 16'h0000);
      rd(8'h50, rv);
      chk(rv, 16'h0000);
      $display("test reset done");
      // eight slots with boundary numbers, then the interrupt path
      load(0, '{8'h05, 8'h06, 8'hc9, 8'h07, 8'h09, 8'h80, 8'h01, 8'hcf});
      exp_pk = '{16'h6, 16'h0, 16'h0, 16'h8, 16'ha, 16'h0, 16'h2, 16'h0};
      cmd(0, 4'h8);
      wait_done(0, 1'b0);
      chk_blk(0, 16'h0000, 4'h8);
      chk(16'(n_start[0]), 16'h0008);
      rd(`PSR_ADDR_STATUS, rv);
      chk(rv, 16'h0001);
      chk(16'(irq), 16'h0000);
      wr(`PSR_ADDR_MASK, 16'h0001);
      chk(16'(irq), 16'h0001);
      wr(`PSR_ADDR_STATUS, 16'h0001);
      chk(16'(irq), 16'h0000);
      $display("test eight slots done");
      // error in slot two skips the rest
      load(1, '{8'h03, 8'h64, 8'h05, 8'h07, 8'h01, 8'h01, 8'h01, 8'h01});
      exp_pk = '{default: 16'h0000};
      exp_pk[0] = 16'h0004;
      cmd(1, 4'h4);
      wait_done(1, 1'b1);
      chk_blk(1, ERR_CODE, 4'h2);
      chk(16'(n_start[1]), 16'h0002);
      $display("test stop on error done");
      // invalid counts and protocol numbers
      exp_pk[0] = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         wr(base(0) + 8'h02, {8'h00, bad[i][7:0]});
         cmd(0, bad[i][11:8]);
         wait_done(0, 1'b1);
         chk_blk(0, `PSR_ERR_PARAM, 4'h0);
      end
      chk(16'(n_start[0]), 16'h0008);
      wr(`PSR_ADDR_STATUS, 16'h003f);
      wr(`PSR_ADDR_CMD, 16'h0010);
      wr(`PSR_ADDR_CMD, 16'h0013);
      rd(`PSR_ADDR_STATUS, rv);
      chk(rv, 16'h0010);
      $display("test invalid setup done");
      // busy channel, concurrent channel, reinit clash and cancel
      slow <= 2'b01;
      wr(base(0) + 8'h02, 16'h0005);
      cmd(0, 4'h2);
      cmd(0, 4'h1);
      reinit_req <= 2'b01;
      #1 chk(16'(reinit_reject), 16'h0001);
      @(posedge core_clk);
      reinit_req <= 2'b00;
      exp_pk[0] = 16'h0004;
      cmd(1, 4'h1);
      wait_done(1, 1'b0);
      chk_blk(1, 16'h0000, 4'h1);
      chk(16'(busy[0]), 16'h0001);
      exp_pk[0] = 16'h0000;
      wr(`PSR_ADDR_CANCEL0, 16'h0001);
      wait_done(0, 1'b1);
      chk_blk(0, `PSR_ERR_CANCEL, 4'h1);
      rd(`PSR_ADDR_CANCEL0, rv);
      chk(rv, 16'h0002);
      chk(16'(n_start[0]), 16'h0009);
      rd(`PSR_ADDR_STATUS, rv);
      chk(rv, 16'h0037);
      wr(`PSR_ADDR_CANCEL0, 16'h0001);
      rd(`PSR_ADDR_CANCEL0, rv);
      chk(rv, 16'h0002);
      wr(`PSR_ADDR_CANCEL1, 16'h0001);
      rd(`PSR_ADDR_CANCEL1, rv);
      chk(rv, 16'h0002);
      slow <= 2'b00;
      $display("test busy and cancel done");
      // reinit in progress, then other protocol mode on channel one
      reinit_busy <= 2'b01;
      cmd(0, 4'h1);
      wait_done(0, 1'b1);
      chk_blk(0, `PSR_ERR_SIMUL, 4'h0);
      reinit_busy <= 2'b00;
      mode_conflict <= 2'b01;
      cmd(0, 4'h1);
      wait_done(0, 1'b1);
      chk_blk(0, `PSR_ERR_MODE, 4'h0);
      mode_conflict <= 2'b00;
      chk(16'(n_start[0]), 16'h0009);
      $display("test clash done");
      close_out();
   end
endmodule
`default_nettype wire
